// File: hw/rtc_serial_pkg.sv
// Shared constants, carrier types and helpers of the clock's serial port
package rtc_serial_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [7:0] TRICKLE_RD_ADDR = 8'h11;
	localparam logic [7:0] TRICKLE_WR_ADDR = 8'h91;
	localparam logic [6:0] TRICKLE_PTR = TRICKLE_RD_ADDR[6:0];
	localparam logic [6:0] CTRL_PTR = 7'h0f;
	localparam logic [6:0] STATUS_PTR = 7'h10;
	localparam logic [6:0] CLOCK_FIRST = 7'h00;
	localparam logic [6:0] CLOCK_LAST = 7'h1f;
	localparam logic [6:0] RAM_FIRST = 7'h20;
	localparam logic [6:0] RAM_LAST = 7'h7f;
	localparam logic [6:0] ALARM0_FIRST = 7'h07;
	localparam logic [6:0] ALARM0_LAST = 7'h0a;

	// ----------------------------------------------------------------
	// Field positions and values after reset
	// ----------------------------------------------------------------
	localparam int DIR_BIT = 7;
	localparam int WP_BIT = 6;
	localparam int ALARM0_FLAG_BIT = 0;
	localparam logic [7:0] CTRL_WR_MASK = 8'h47;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] TRICKLE_RESET = 8'h5c;
	localparam logic [3:0] CHARGER_KEY = 4'ha;
	localparam logic [1:0] DIODE_ONE = 2'h1;
	localparam logic [1:0] DIODE_TWO = 2'h2;
	localparam logic [1:0] RES_NONE = 2'h0;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] charger_select_field;
		logic [1:0] diode_select_field;
		logic [1:0] resistor_select_field;
	} trickle_t;

	typedef struct packed {
		logic enable;
		logic two_diodes;
		logic [1:0] res_sel;
	} charge_cfg_t;

	typedef struct packed {
		logic [6:0] ptr;
		logic [7:0] data;
	} wr_req_t;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Burst pointer step; clock and RAM regions wrap on their own
	function automatic logic [6:0] next_ptr(input logic [6:0] p);
		logic [6:0] n;
		n = p + 7'h01;
		if (p == CLOCK_LAST) begin
			n = CLOCK_FIRST;
		end else if (p == RAM_LAST) begin
			n = RAM_FIRST;
		end
		return n;
	endfunction

	function automatic logic in_alarm0(input logic [6:0] p);
		return (p >= ALARM0_FIRST) && (p <= ALARM0_LAST);
	endfunction

	// Charger is on only for the key, a legal diode code and a resistor
	function automatic charge_cfg_t decode_trickle(input trickle_t t);
		charge_cfg_t c;
		c.enable = (t.charger_select_field == CHARGER_KEY)
			&& ((t.diode_select_field == DIODE_ONE)
			|| (t.diode_select_field == DIODE_TWO))
			&& (t.resistor_select_field != RES_NONE);
		c.two_diodes = c.enable && (t.diode_select_field == DIODE_TWO);
		c.res_sel = c.enable ? t.resistor_select_field : RES_NONE;
		return c;
	endfunction

endpackage

// File: hw/level_sync.sv
// Two-flop synchroniser for a level entering the system clock domain
`timescale 1ns/1ps
module level_sync (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic d,
	output logic q
);
	logic meta_r;
	logic meta_nxt;
	logic q_nxt;

	// Next values; the first stage feeds only the second
	always_comb begin
		meta_nxt = clk_en ? d : meta_r;
		q_nxt = clk_en ? meta_r : q;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			q <= q_nxt;
		end
	end
endmodule

// File: hw/toggle_pulse.sv
// Turns a toggle from another clock domain into a one-cycle pulse
`timescale 1ns/1ps
module toggle_pulse (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic tgl,
	output logic pulse
);
	logic sync_q;
	logic last_r;
	logic last_nxt;

	level_sync u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clk_en(clk_en),
		.d(tgl),
		.q(sync_q)
	);

	// Edge of the synchronised toggle; held while the enable is low
	always_comb begin
		last_nxt = clk_en ? sync_q : last_r;
		pulse = clk_en && (sync_q != last_r);
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			last_r <= 1'b0;
		end else begin
			last_r <= last_nxt;
		end
	end
endmodule

// File: hw/rtc_serial_slave_port.sv
// Serial slave port of a real-time clock with its register store
// Operation
// RULE1: Trickle register reads at address 11h and is written at 91h.
// RULE2: Charger enables only when select field bits 7..4 hold 1010.
// RULE3: After reset trickle register is 0101 11 00, charger off.
// RULE4: Diode field 01 means one diode, 10 two; 00 or 11 off.
// RULE5: Resistor field 01/10/11 picks 2k/4k/8k; 00 turns charger off.
// RULE6: No register or RAM write while running on battery.
// RULE7: Mode pin high gives four-wire mode, low gives three-wire mode.
// RULE8: Serial clock level at chip-enable rise sets clock polarity.
// RULE9: Four-wire: latch on strobe edge, shift out on other; bytes.
// RULE10: Four-wire bytes move most significant bit first, both lines.
// RULE11: First byte is address; top bit 0 reads, 1 writes.
// RULE12: Pointer steps after each data byte until chip-enable drops.
// RULE13: Clock region wraps 1Fh to 00h reading, 9Fh to 80h writing.
// RULE14: RAM region wraps 7Fh to 20h reading, FFh to A0h writing.
// RULE15: Master keeps chip-enable high and clocks until burst ends.
// RULE16: Master drops chip-enable after one data byte for single.
// RULE17: Reads drive data on serial output; writes take serial input.
// RULE18: Three-wire uses one shared data line, bytes LSB first.
// RULE19: Three-wire captures on rising clock, changes output on falling.
// RULE20: Write protect blocks every write except clearing that bit.
// RULE21: Pointer touching any alarm 0 register clears its request flag.
// RULE22: Output released when deselected, in address and write phases.
`timescale 1ns/1ps
module rtc_serial_slave_port (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic link_clk,
	input wire logic ce,
	input wire logic interface_mode_pin,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe_n,
	input wire logic on_battery,
	input wire logic alarm0_match,
	output logic alarm0_request_flag,
	output logic write_protect,
	output logic charger_enable,
	output logic two_diodes,
	output logic [1:0] resistor_select
);

	// ----------------------------------------------------------------
	// System-side storage, read by the link side
	// ----------------------------------------------------------------
	logic [7:0] mem [0:127];
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	rtc_serial_pkg::trickle_t trickle_r;
	rtc_serial_pkg::trickle_t trickle_nxt;
	rtc_serial_pkg::charge_cfg_t cfg_r;
	rtc_serial_pkg::charge_cfg_t cfg_nxt;
	logic alarm0_r;
	logic alarm0_nxt;

	// ----------------------------------------------------------------
	// Link-side state
	// ----------------------------------------------------------------
	logic frame_rst_n;
	logic wire3_r;
	logic idle_high_r;
	logic strobe_clk;
	logic [2:0] bit_cnt_r;
	logic [2:0] bit_cnt_nxt;
	logic [7:0] shin_r;
	logic [7:0] shin_nxt;
	logic addr_phase_r;
	logic addr_phase_nxt;
	logic dir_wr_r;
	logic dir_wr_nxt;
	logic [6:0] ptr_r;
	logic [6:0] ptr_nxt;
	rtc_serial_pkg::wr_req_t wr_req_r;
	rtc_serial_pkg::wr_req_t wr_req_nxt;
	logic wr_tgl_r;
	logic wr_tgl_nxt;
	logic clr_tgl_r;
	logic clr_tgl_nxt;
	logic [7:0] shout_r;
	logic [7:0] shout_nxt;
	logic [2:0] ocnt_r;
	logic [2:0] ocnt_nxt;
	logic out_bit_r;
	logic out_bit_nxt;
	logic drive_r;
	logic drive_nxt;
	logic [7:0] rd_byte;

	// ----------------------------------------------------------------
	// Crossings into the system domain
	// ----------------------------------------------------------------
	logic on_batt_s;
	logic wr_pulse;
	logic clr_pulse;

	level_sync u_batt_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clk_en(clk_en),
		.d(on_battery),
		.q(on_batt_s)
	);

	toggle_pulse u_wr_pulse (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clk_en(clk_en),
		.tgl(wr_tgl_r),
		.pulse(wr_pulse)
	);

	toggle_pulse u_clr_pulse (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clk_en(clk_en),
		.tgl(clr_tgl_r),
		.pulse(clr_pulse)
	);

	// ----------------------------------------------------------------
	// Frame setup on the chip-enable rise
	// ----------------------------------------------------------------
	// Frame state is cleared by the frame's own end, not by a clock edge
	assign frame_rst_n = ce & resetn;

	// Mode and idle level follow the pins while deselected and hold from
	// the enable rise; a flop clocked by that rise would flip the strobe
	// polarity just after the frame reset lifts and fake a first bit.
	// Strobe glitches while deselected meet state held in reset or toggles that reload their own value.
	always_latch begin
		if (!ce) begin
			wire3_r <= ~interface_mode_pin; // RULE7
			idle_high_r <= link_clk; // RULE8
		end
	end

	// Strobe edge is the rising edge of this clock: falling for idle
	// low, rising for idle high, always rising in three-wire mode
	assign strobe_clk = (wire3_r | idle_high_r) ? link_clk : ~link_clk; // RULE9 RULE19

	// ----------------------------------------------------------------
	// Strobe edge: bit capture, address decode, pointer stepping
	// ----------------------------------------------------------------
	always_comb begin
		bit_cnt_nxt = bit_cnt_r + 3'h1;
		addr_phase_nxt = addr_phase_r;
		dir_wr_nxt = dir_wr_r;
		ptr_nxt = ptr_r;
		wr_req_nxt = wr_req_r;
		wr_tgl_nxt = wr_tgl_r;
		clr_tgl_nxt = clr_tgl_r;
		if (wire3_r) begin
			shin_nxt = {sdi, shin_r[7:1]}; // RULE18
		end else begin
			shin_nxt = {shin_r[6:0], sdi}; // RULE10
		end
		if (bit_cnt_r == rtc_serial_pkg::BYTE_LAST_BIT) begin
			if (addr_phase_r) begin
				addr_phase_nxt = 1'b0; // RULE11
				dir_wr_nxt = shin_nxt[rtc_serial_pkg::DIR_BIT];
				ptr_nxt = shin_nxt[6:0]; // RULE1
			end else begin
				if (dir_wr_r) begin
					wr_req_nxt.ptr = ptr_r; // RULE17
					wr_req_nxt.data = shin_nxt;
					wr_tgl_nxt = ~wr_tgl_r;
				end
				ptr_nxt = rtc_serial_pkg::next_ptr(ptr_r); // RULE12 RULE13 RULE14
			end
			if (rtc_serial_pkg::in_alarm0(ptr_nxt)) begin
				clr_tgl_nxt = ~clr_tgl_r; // RULE21
			end
		end
	end

	// Per-frame state starts over at every chip-enable rise
	always_ff @(posedge strobe_clk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_r <= 3'h0;
			shin_r <= 8'h00;
			addr_phase_r <= 1'b1;
			dir_wr_r <= 1'b0;
			ptr_r <= 7'h00;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			shin_r <= shin_nxt;
			addr_phase_r <= addr_phase_nxt;
			dir_wr_r <= dir_wr_nxt;
			ptr_r <= ptr_nxt;
		end
	end

	// Toggles and the write holding word survive the frame end, so that
	// dropping chip-enable never fakes an event on the other side
	always_ff @(posedge strobe_clk or negedge resetn) begin
		if (!resetn) begin
			wr_req_r <= '0;
			wr_tgl_r <= 1'b0;
			clr_tgl_r <= 1'b0;
		end else begin
			wr_req_r <= wr_req_nxt;
			wr_tgl_r <= wr_tgl_nxt;
			clr_tgl_r <= clr_tgl_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read mux; storage other than the alarm 0 flag only changes through this same link
	// ----------------------------------------------------------------
	// The link side samples system flops directly: all but the alarm 0 flag are quiet while
	// a read byte is loaded, so no handshake is needed here
	always_comb begin
		if (ptr_r == rtc_serial_pkg::CTRL_PTR) begin
			rd_byte = ctrl_r;
		end else if (ptr_r == rtc_serial_pkg::STATUS_PTR) begin
			rd_byte = 8'h00;
			rd_byte[rtc_serial_pkg::ALARM0_FLAG_BIT] = alarm0_r;
		end else if (ptr_r == rtc_serial_pkg::TRICKLE_PTR) begin
			rd_byte = trickle_r; // RULE1
		end else if ((ptr_r > rtc_serial_pkg::TRICKLE_PTR)
			&& (ptr_r <= rtc_serial_pkg::CLOCK_LAST)) begin
			rd_byte = 8'h00;
		end else begin
			rd_byte = mem[ptr_r];
		end
	end

	// ----------------------------------------------------------------
	// Shift edge: serial output in read bursts
	// ----------------------------------------------------------------
	always_comb begin
		shout_nxt = shout_r;
		ocnt_nxt = ocnt_r;
		out_bit_nxt = out_bit_r;
		drive_nxt = 1'b0; // RULE22
		if (!addr_phase_r && !dir_wr_r) begin
			drive_nxt = 1'b1; // RULE17
			ocnt_nxt = ocnt_r + 3'h1;
			if (ocnt_r == 3'h0) begin
				if (wire3_r) begin
					out_bit_nxt = rd_byte[0]; // RULE18
					shout_nxt = {1'b0, rd_byte[7:1]};
				end else begin
					out_bit_nxt = rd_byte[7]; // RULE10
					shout_nxt = {rd_byte[6:0], 1'b0};
				end
			end else if (wire3_r) begin
				out_bit_nxt = shout_r[0];
				shout_nxt = {1'b0, shout_r[7:1]};
			end else begin
				out_bit_nxt = shout_r[7];
				shout_nxt = {shout_r[6:0], 1'b0};
			end
		end
	end

	// Output changes on the edge opposite the strobe
	always_ff @(negedge strobe_clk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			shout_r <= 8'h00;
			ocnt_r <= 3'h0;
			out_bit_r <= 1'b0;
			drive_r <= 1'b0;
		end else begin
			shout_r <= shout_nxt; // RULE9 RULE19
			ocnt_r <= ocnt_nxt;
			out_bit_r <= out_bit_nxt;
			drive_r <= drive_nxt;
		end
	end

	assign sdo = out_bit_r;
	assign sdo_oe_n = ~drive_r; // RULE22

	// ----------------------------------------------------------------
	// System side: write acceptance and register updates
	// ----------------------------------------------------------------
	logic wp_set;
	logic wr_ok;
	logic wr_mem;

	// Only a control write that clears protection gets past it
	always_comb begin
		wp_set = ctrl_r[rtc_serial_pkg::WP_BIT];
		wr_ok = wr_pulse && !on_batt_s // RULE6
			&& (!wp_set || ((wr_req_r.ptr == rtc_serial_pkg::CTRL_PTR)
			&& !wr_req_r.data[rtc_serial_pkg::WP_BIT])); // RULE20
		wr_mem = wr_ok && ((wr_req_r.ptr < rtc_serial_pkg::CTRL_PTR)
			|| (wr_req_r.ptr >= rtc_serial_pkg::RAM_FIRST));
	end

	// Register next values; a cleared protect bit leaves the others alone
	always_comb begin
		ctrl_nxt = ctrl_r;
		trickle_nxt = trickle_r;
		if (wr_ok && (wr_req_r.ptr == rtc_serial_pkg::CTRL_PTR)) begin
			if (wp_set) begin
				ctrl_nxt[rtc_serial_pkg::WP_BIT] = 1'b0; // RULE20
			end else begin
				ctrl_nxt = wr_req_r.data & rtc_serial_pkg::CTRL_WR_MASK;
			end
		end
		if (wr_ok && (wr_req_r.ptr == rtc_serial_pkg::TRICKLE_PTR)) begin
			trickle_nxt = wr_req_r.data; // RULE1
		end
		// A match in the clearing cycle still leaves the flag set
		alarm0_nxt = alarm0_match || (alarm0_r && !clr_pulse); // RULE21
		cfg_nxt = rtc_serial_pkg::decode_trickle(trickle_r); // RULE2 RULE4 RULE5
		if (!clk_en) begin
			ctrl_nxt = ctrl_r;
			trickle_nxt = trickle_r;
			alarm0_nxt = alarm0_r;
			cfg_nxt = cfg_r;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= rtc_serial_pkg::CTRL_RESET;
			trickle_r <= rtc_serial_pkg::TRICKLE_RESET; // RULE3
			alarm0_r <= 1'b0;
			cfg_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			trickle_r <= trickle_nxt;
			alarm0_r <= alarm0_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	// Clock and RAM bytes keep no reset value, like backed-up storage
	always_ff @(posedge clk_sys) begin
		if (wr_mem) begin
			mem[wr_req_r.ptr] <= wr_req_r.data; // RULE6
		end
	end

	// ----------------------------------------------------------------
	// Outputs from flops
	// ----------------------------------------------------------------
	assign alarm0_request_flag = alarm0_r;
	assign write_protect = ctrl_r[rtc_serial_pkg::WP_BIT];
	assign charger_enable = cfg_r.enable;
	assign two_diodes = cfg_r.two_diodes;
	assign resistor_select = cfg_r.res_sel;

endmodule

// File: sim/serial_master_model.sv
// Behavioural serial bus master facing the clock's serial port
`timescale 1ns/1ps
module serial_master_model (
	output logic link_clk,
	output logic ce,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe_n
);
	logic four = 1'b1;
	logic drv = 1'b0;
	// ------------------------------------------------------------
	// Shared line
	// ------------------------------------------------------------
	// Three-wire: the device owns the line while its driver is on
	assign sdi = (!four && !sdo_oe_n) ? sdo : drv;
	initial begin
		link_clk = 1'b0;
		ce = 1'b0;
	end
	// Clock rests at its idle level before the frame opens
	task automatic open_frame(input logic four_wire, input logic idle);
		four = four_wire;
		link_clk = idle;
		#37 ce = 1'b1;
		#30;
	endtask
	// One byte; a listening master toggles its line so stale data shows
	task automatic xfer(input logic [7:0] tx, input logic talk,
		output logic [7:0] rx);
		int i;
		logic b;
		for (i = 0; i < 8; i++) begin
			drv = talk ? (four ? tx[7 - i] : tx[i]) : ~drv;
			#12;
			b = sdi;
			link_clk = ~link_clk;
			#24;
			if (four) b = sdo_oe_n ? ~sdo : sdo; // Released line misreads
			link_clk = ~link_clk;
			#12;
			if (four) rx[7 - i] = b; else rx[i] = b;
		end
	endtask
	// Clock stays still once the last byte has moved
	task automatic close_frame();
		#30 ce = 1'b0;
		#100;
	endtask
endmodule

// File: sim/rtc_serial_slave_port_checker.sv
// Concurrent checks on the ports of the clock's serial port
`timescale 1ns/1ps
module rtc_serial_slave_port_checker (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic link_clk,
	input wire logic ce,
	input wire logic sdo_oe_n,
	input wire logic on_battery,
	input wire logic alarm0_match,
	input wire logic alarm0_request_flag,
	input wire logic write_protect,
	input wire logic charger_enable,
	input wire logic two_diodes,
	input wire logic [1:0] resistor_select
);
	logic [3:0] edge_cnt_r;
	// ------------------------------------------------------------
	// Helper: rising link edges since the frame opened
	// ------------------------------------------------------------
	// Cleared by ce so a short frame never leaks into the next one
	always_ff @(posedge link_clk or negedge ce) begin
		if (!ce) edge_cnt_r <= 4'h0;
		else if (edge_cnt_r != 4'hf) edge_cnt_r <= edge_cnt_r + 4'h1;
	end
	oe_released_a: assert property (@(posedge clk_sys)
		disable iff (!resetn) !ce |-> sdo_oe_n) else $error("sdo driven");
	addr_quiet_a: assert property (@(posedge link_clk)
		disable iff (!resetn) ce && edge_cnt_r < 4'h8 |-> sdo_oe_n)
		else $error("sdo driven in address");
	reset_state_a: assert property (@(posedge clk_sys)
		disable iff (!resetn) $rose(resetn) |->
		!charger_enable && !write_protect && sdo_oe_n)
		else $error("bad state after reset");
	diode_pair_a: assert property (@(posedge clk_sys)
		disable iff (!resetn) two_diodes |-> charger_enable)
		else $error("two diodes while off");
	res_pair_a: assert property (@(posedge clk_sys)
		disable iff (!resetn) charger_enable == (resistor_select != 2'h0))
		else $error("resistor and enable disagree");
	batt_hold_a: assert property (@(posedge clk_sys)
		disable iff (!resetn) on_battery [*8] |=>
		$stable({charger_enable, two_diodes, resistor_select, write_protect}))
		else $error("write on battery");
	wp_hold_a: assert property (@(posedge clk_sys)
		disable iff (!resetn) write_protect [*6] |=>
		$stable({charger_enable, two_diodes, resistor_select}))
		else $error("write under protection");
	alarm_set_a: assert property (@(posedge clk_sys)
		disable iff (!resetn) alarm0_match && clk_en |=> alarm0_request_flag)
		else $error("alarm flag not set");
	cover property (@(posedge clk_sys) $rose(charger_enable));
	cover property (@(posedge clk_sys) $rose(write_protect));
	cover property (@(posedge link_clk) !sdo_oe_n);
endmodule
bind rtc_serial_slave_port rtc_serial_slave_port_checker checker_i (
	.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
	.link_clk(link_clk), .ce(ce), .sdo_oe_n(sdo_oe_n),
	.on_battery(on_battery), .alarm0_match(alarm0_match),
	.alarm0_request_flag(alarm0_request_flag),
	.write_protect(write_protect), .charger_enable(charger_enable),
	.two_diodes(two_diodes), .resistor_select(resistor_select));

// File: sim/tb_rtc_serial_slave_port.sv
// Self-checking bench of the clock's serial port
`timescale 1ns/1ps
module tb_rtc_serial_slave_port;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic interface_mode_pin = 1'b1;
	logic on_battery = 1'b0;
	logic alarm0_match = 1'b0;
	logic clk_en = 1'b1;
	logic link_clk, ce, sdi, sdo, sdo_oe_n, alarm0_request_flag;
	logic write_protect, charger_enable, two_diodes;
	logic [1:0] resistor_select;
	logic [7:0] txb [4];
	logic [7:0] rxb [4];
	int n_errors = 0;
	int n_checks = 0;
	always #5 clk_sys = ~clk_sys;
	rtc_serial_slave_port rtc_serial_slave_port_i (.clk_sys(clk_sys),
		.resetn(resetn), .clk_en(clk_en), .link_clk(link_clk), .ce(ce),
		.interface_mode_pin(interface_mode_pin), .sdi(sdi), .sdo(sdo),
		.sdo_oe_n(sdo_oe_n), .on_battery(on_battery),
		.alarm0_match(alarm0_match),
		.alarm0_request_flag(alarm0_request_flag),
		.write_protect(write_protect), .charger_enable(charger_enable),
		.two_diodes(two_diodes), .resistor_select(resistor_select));
	serial_master_model serial_master_model_i (.link_clk(link_clk),
		.ce(ce), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Charger outputs expected for a trickle byte
	function automatic logic [7:0] exp_cfg(input logic [7:0] v);
		logic en;
		en = v[7:4] == 4'ha && (v[3:2] == 2'h1 || v[3:2] == 2'h2)
			&& v[1:0] != 2'h0;
		return {4'h0, en, en && v[3:2] == 2'h2, en ? v[1:0] : 2'h0};
	endfunction
	function automatic logic [7:0] cfg();
		return {4'h0, charger_enable, two_diodes, resistor_select};
	endfunction
	// Address then n data bytes; bit 7 of the address says who talks
	task automatic run(input logic idle, input logic [7:0] a, input int n);
		logic [7:0] junk;
		@(posedge clk_sys); // Let a pin set by the caller settle first
		serial_master_model_i.open_frame(interface_mode_pin, idle);
		serial_master_model_i.xfer(a, 1'b1, junk);
		for (int k = 0; k < n; k++) begin
			serial_master_model_i.xfer(txb[k], a[7], rxb[k]);
		end
		serial_master_model_i.close_frame();
	endtask
	task automatic wr1(input logic [7:0] a, input logic [7:0] d);
		txb[0] = d;
		run(1'b0, a, 1);
	endtask
	task automatic rd1(input logic [7:0] a, input logic [7:0] exp);
		run(1'b0, a, 1);
		chk(rxb[0], exp);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk({3'h0, charger_enable, two_diodes, resistor_select, sdo_oe_n},
			8'h01);
		rd1(8'h11, 8'h5c);
		$display("reset test done");
	endtask
	task automatic t_decode();
		logic [7:0] v [11] = '{8'ha5, 8'ha6, 8'ha7, 8'haa, 8'hab, 8'ha1,
			8'had, 8'ha8, 8'hb9, 8'h59, 8'ha9};
		foreach (v[i]) begin
			wr1(8'h91, v[i]);
			chk(cfg(), exp_cfg(v[i]));
		end
		rd1(8'h11, 8'ha9);
		$display("decode test done");
	endtask
	// Bursts across both wrap points, read back at both polarities
	task automatic t_burst();
		txb[0] = 8'h11;
		txb[1] = 8'h22;
		run(1'b0, 8'hff, 2);
		txb[0] = 8'h77;
		txb[1] = 8'h5a;
		run(1'b0, 8'h9f, 2);
		run(1'b0, 8'h7f, 2);
		chk(rxb[0], 8'h11);
		chk(rxb[1], 8'h22);
		run(1'b1, 8'h1f, 2);
		chk(rxb[0], 8'h00);
		chk(rxb[1], 8'h5a);
		$display("burst test done");
	endtask
	task automatic t_wp();
		wr1(8'h8f, 8'h40);
		chk({7'h0, write_protect}, 8'h01);
		wr1(8'ha0, 8'h33);
		wr1(8'h91, 8'ha5);
		chk(cfg(), exp_cfg(8'ha9));
		rd1(8'h20, 8'h22);
		wr1(8'h8f, 8'h47);
		chk({7'h0, write_protect}, 8'h01);
		wr1(8'h8f, 8'h00);
		chk({7'h0, write_protect}, 8'h00);
		$display("protect test done");
	endtask
	task automatic t_batt();
		@(posedge clk_sys);
		on_battery <= 1'b1;
		repeat (4) @(posedge clk_sys);
		wr1(8'h91, 8'ha6);
		wr1(8'ha0, 8'h44);
		rd1(8'h11, 8'ha9);
		rd1(8'h20, 8'h22);
		@(posedge clk_sys);
		on_battery <= 1'b0;
		$display("battery test done");
	endtask
	// Three-wire bytes read back over four wires expose the bit order
	task automatic t_three();
		@(posedge clk_sys);
		interface_mode_pin <= 1'b0;
		txb[0] = 8'hc3;
		txb[1] = 8'h1e;
		run(1'b0, 8'ha5, 2);
		run(1'b0, 8'h25, 2);
		chk(rxb[0], 8'hc3);
		chk(rxb[1], 8'h1e);
		@(posedge clk_sys);
		interface_mode_pin <= 1'b1;
		rd1(8'h26, 8'h1e);
		$display("three-wire test done");
	endtask
	task automatic t_alarm();
		@(posedge clk_sys);
		alarm0_match <= 1'b1;
		@(posedge clk_sys);
		alarm0_match <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk({7'h0, alarm0_request_flag}, 8'h01);
		rd1(8'h10, 8'h01);
		wr1(8'h87, 8'h00);
		chk({7'h0, alarm0_request_flag}, 8'h00);
		rd1(8'h10, 8'h00);
		$display("alarm test done");
	endtask
	// A low enable holds the flag and defers a link write until it rises
	task automatic t_freeze();
		@(posedge clk_sys);
		clk_en <= 1'b0;
		alarm0_match <= 1'b1;
		@(posedge clk_sys);
		alarm0_match <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk({7'h0, alarm0_request_flag}, 8'h00);
		wr1(8'h91, 8'ha5);
		chk(cfg(), exp_cfg(8'ha9));
		@(posedge clk_sys);
		clk_en <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk(cfg(), exp_cfg(8'ha5));
		$display("enable test done");
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Whole sequence needs about 36 us; a hang is cut well beyond that
	initial begin
		#300000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_decode();
		t_burst();
		t_wp();
		t_batt();
		t_three();
		t_alarm();
		t_freeze();
		report_and_stop();
	end
endmodule
